/* shared/pmc_pkg.sv */
/*
 * Shared constants and types of the PDM microphone capture block.
 * Assumes a 250 MHz system clock and one or two PDM microphones on one data pin.
 */
// Notes on behaviour
// - Recognition modes take one microphone on the clock output and data input.
// - Recognition modes run the microphone clock at 1.024 MHz.
// - Recognition modes feed one path to detection, the other to the TDM bus.
// - A host or flash setting picks the edge each channel is sampled on.
// - Full duplex mode takes two microphones on the shared clock and data pins.
// - Full duplex clock is 1.024 MHz at 8/16 kHz TDM-A, 3.072 MHz at 48 kHz.
// - The bit stream is decimated and filtered to 8 kHz or 16 kHz.
// - Without TDM-A the clock runs from the crystal and audio passes at 48 kHz.
// - Full duplex feeds one path to voice processing, the other to TDM.
// - Echo cancellation acts only on the path that feeds voice processing.
// - Two microphones share the pin, one per edge; each edge is captured.
package pmc_pkg;

    // Firmware operating modes.
    typedef enum logic [1:0] {
        PMC_MODE_DUPLEX = 2'h0,
        PMC_MODE_ASR = 2'h1,
        PMC_MODE_BARGE = 2'h2
    } pmc_mode_t;

    // Sample rates of the first TDM port.
    typedef enum logic [1:0] {
        PMC_RATE_8K = 2'h0,
        PMC_RATE_16K = 2'h1,
        PMC_RATE_48K = 2'h2
    } pmc_rate_t;

    // Clock rates in Hz.
    localparam longint PMC_SYS_HZ = 250000000;
    localparam longint PMC_PDM_LO_HZ = 1024000;
    localparam longint PMC_PDM_HI_HZ = 3072000;

    // Phase accumulator width and the increments derived from the rates.
    localparam int PMC_ACC_W = 24;
    localparam logic [23:0] PMC_INC_LO = 24'((PMC_PDM_LO_HZ * (64'h1 << PMC_ACC_W)) / PMC_SYS_HZ);
    localparam logic [23:0] PMC_INC_HI = 24'((PMC_PDM_HI_HZ * (64'h1 << PMC_ACC_W)) / PMC_SYS_HZ);

    // Decimation ratios: PDM bits per output word.
    localparam logic [8:0] PMC_DEC_LO_16K = 9'h040;
    localparam logic [8:0] PMC_DEC_LO_8K = 9'h080;
    localparam logic [8:0] PMC_DEC_HI_16K = 9'h0C0;
    localparam logic [8:0] PMC_DEC_HI_8K = 9'h180;
    localparam logic [8:0] PMC_DEC_48K = 9'h040;

    // Cycles from an internal clock edge to the synchronised pin value.
    localparam int PMC_SYNC_LAG = 3;

    // Width of an audio word.
    localparam int PMC_WORD_W = 16;

endpackage

/* rtl/pmc_pair_buf.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on the same clock; outputs come from flip-flops.
 */
`timescale 1ns/1ps
module pmc_pair_buf #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready_q,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid_q,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data_q
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [WIDTH-1:0] spare_q;
    logic push;
    logic pop;

    // A push is refused while full, so a full buffer never pushes and pops at once.
    always_comb begin
        push = in_valid && in_ready_q;
        pop = out_valid_q && out_ready;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // Occupancy and the registered handshake flags.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 2'h0;
            in_ready_q <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != 2'h2);
            out_valid_q <= (cnt_d != 2'h0);
        end
    end

    // Head word shown to the drain, spare word behind it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_data_q <= '0;
            spare_q <= '0;
        end else begin
            if (pop && cnt_q == 2'h2) begin
                out_data_q <= spare_q;
            end else if (push && (cnt_q == 2'h0 || pop)) begin
                out_data_q <= in_data;
            end
            if (push && cnt_q == 2'h1 && !pop) begin
                spare_q <= in_data;
            end
        end
    end

endmodule

/* rtl/pmc_capture.sv */
/*
 * PDM microphone capture: makes the microphone clock, samples both edge channels,
 * decimates them and steers one to voice processing and the other to the TDM bus.
 * Assumes mode and rate settings come from logic on clk; the data pin is asynchronous.
 */
`timescale 1ns/1ps
module pmc_capture (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Configuration from the host port or the flash record.
    input wire pmc_pkg::pmc_mode_t mode,
    input wire logic tdm_a_present,
    input wire pmc_pkg::pmc_rate_t tdm_a_rate,
    input wire logic proc_rate_16k,
    input wire logic chan0_rising,
    input wire logic proc_sel,
    // Microphone pins.
    output logic pdm_clock_out_q,
    input wire logic pdm_data_in,
    // Stream to voice or detection processing.
    output logic proc_valid_q,
    input wire logic proc_ready,
    output logic [15:0] proc_data_q,
    // Stream to the TDM bus.
    output logic tdm_valid_q,
    input wire logic tdm_ready,
    output logic [15:0] tdm_data_q,
    // Status.
    output logic echo_cancel_ch_q,
    output logic overrun_q
);

    logic freq_hi;
    logic [8:0] ratio;
    logic [9:0] cfg_q;
    logic cfg_chg;
    logic [23:0] acc_q;
    logic sync1_q;
    logic sync2_q;
    logic [2:0] rise_sh_q;
    logic [2:0] fall_sh_q;
    logic rise_ev;
    logic fall_ev;
    logic [8:0] bit_cnt_q;
    logic dump;
    logic [1:0] samp_ev;
    logic [8:0] ones_q [2];
    logic [8:0] ones_nx [2];
    logic [15:0] word [2];
    logic proc_in_ready;
    logic tdm_in_ready;

    // Clock and decimation choice from the mode and the TDM-A rate.
    always_comb begin
        freq_hi = (mode == pmc_pkg::PMC_MODE_DUPLEX) &&
                  (!tdm_a_present || tdm_a_rate == pmc_pkg::PMC_RATE_48K);
        if (!tdm_a_present && mode == pmc_pkg::PMC_MODE_DUPLEX) begin
            ratio = pmc_pkg::PMC_DEC_48K;
        end else if (freq_hi) begin
            ratio = proc_rate_16k ? pmc_pkg::PMC_DEC_HI_16K : pmc_pkg::PMC_DEC_HI_8K;
        end else begin
            ratio = proc_rate_16k ? pmc_pkg::PMC_DEC_LO_16K : pmc_pkg::PMC_DEC_LO_8K;
        end
        cfg_chg = (cfg_q != {freq_hi, ratio});
    end

    // A settings change restarts the decimators so no word mixes two ratios.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= 10'h000;
        end else begin
            cfg_q <= {freq_hi, ratio};
        end
    end

    // Phase accumulator: the truncated fractional step keeps the mean rate less than 8 Hz below target, at the cost of jitter.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= 24'h000000;
            pdm_clock_out_q <= 1'b0;
        end else begin
            acc_q <= acc_q + (freq_hi ? pmc_pkg::PMC_INC_HI : pmc_pkg::PMC_INC_LO);
            pdm_clock_out_q <= acc_q[23];
        end
    end

    // Two-flop synchroniser for the asynchronous data pin.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pdm_data_in;
            sync2_q <= sync1_q;
        end
    end

    // Edge events delayed to line up with the synchronised pin value.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_sh_q <= 3'h0;
            fall_sh_q <= 3'h0;
        end else begin
            rise_sh_q <= {rise_sh_q[1:0], acc_q[23] && !pdm_clock_out_q};
            fall_sh_q <= {fall_sh_q[1:0], !acc_q[23] && pdm_clock_out_q};
        end
    end

    assign rise_ev = rise_sh_q[pmc_pkg::PMC_SYNC_LAG-1];
    assign fall_ev = fall_sh_q[pmc_pkg::PMC_SYNC_LAG-1];

    // One clock period per rising edge; the word closes on the last bit of the block.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q <= 9'h000;
        end else if (cfg_chg) begin
            bit_cnt_q <= 9'h000;
        end else if (rise_ev) begin
            bit_cnt_q <= dump ? 9'h000 : bit_cnt_q + 9'h001;
        end
    end

    assign dump = rise_ev && (bit_cnt_q == ratio - 9'h001) && !cfg_chg;

    // Per-channel capture and boxcar decimator; the word is twice the ones count less the ratio.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign samp_ev[i] = ((i == 0) == chan0_rising) ? rise_ev : fall_ev;
        assign ones_nx[i] = ones_q[i] + {8'h00, samp_ev[i] && sync2_q};
        assign word[i] = {6'h00, ones_nx[i], 1'b0} - {7'h00, ratio};
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ones_q[i] <= 9'h000;
            end else if (cfg_chg || dump) begin
                ones_q[i] <= 9'h000;
            end else begin
                ones_q[i] <= ones_nx[i];
            end
        end
    end

    // Selected channel to processing, the other to the TDM bus.
    pmc_pair_buf #(
        .WIDTH(pmc_pkg::PMC_WORD_W)
    ) u_proc_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(dump),
        .in_ready_q(proc_in_ready),
        .in_data(word[proc_sel]),
        .out_valid_q(proc_valid_q),
        .out_ready(proc_ready),
        .out_data_q(proc_data_q)
    );

    pmc_pair_buf #(
        .WIDTH(pmc_pkg::PMC_WORD_W)
    ) u_tdm_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(dump),
        .in_ready_q(tdm_in_ready),
        .in_data(word[!proc_sel]),
        .out_valid_q(tdm_valid_q),
        .out_ready(tdm_ready),
        .out_data_q(tdm_data_q)
    );

    // Echo cancellation target follows the processing path; overrun marks a dropped word.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_cancel_ch_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            echo_cancel_ch_q <= proc_sel;
            overrun_q <= dump && (!proc_in_ready || !tdm_in_ready);
        end
    end

    // Helper: cycles since the clock pin last moved and since the settings last changed.
    logic [7:0] half_cnt_q;
    logic [9:0] stable_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_cnt_q <= 8'h00;
            stable_q <= 10'h000;
        end else begin
            half_cnt_q <= (acc_q[23] != pdm_clock_out_q) ? 8'h00 : half_cnt_q + 8'h01;
            stable_q <= cfg_chg ? 10'h000 : (stable_q == 10'h3FF ? stable_q : stable_q + 10'h001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence clk_toggles;
        acc_q[23] != pdm_clock_out_q;
    endsequence

    lo_half_period_a: assert property (
        (clk_toggles and stable_q == 10'h3FF and !freq_hi) |-> half_cnt_q inside {[120:122]})
        else $error("slow microphone clock half period out of range");

    hi_half_period_a: assert property (
        (clk_toggles and stable_q == 10'h3FF and freq_hi) |-> half_cnt_q inside {[39:41]})
        else $error("fast microphone clock half period out of range");

    asr_slow_clock_a: assert property (
        (mode != pmc_pkg::PMC_MODE_DUPLEX) |-> !freq_hi && ratio != pmc_pkg::PMC_DEC_HI_8K)
        else $error("recognition mode left the slow microphone clock");

    no_tdm_rate_a: assert property (
        (mode == pmc_pkg::PMC_MODE_DUPLEX && !tdm_a_present) |-> freq_hi && ratio == 9'h040)
        else $error("crystal timing not at 48 kHz output");

    dump_spacing_a: assert property (
        dump |=> !dump [*8])
        else $error("decimated words too close together");

    edge_pick_a: assert property (
        rise_ev |-> (samp_ev[0] == chan0_rising) && (samp_ev[1] == !chan0_rising))
        else $error("edge channels not on opposite edges");

    chan_split_a: assert property (
        (!dump && !cfg_chg && !samp_ev[0]) |=> ones_q[0] == $past(ones_q[0]))
        else $error("channel zero counted off its own edge");

    route_a: assert property (
        (dump && proc_in_ready && proc_valid_q == 1'b0) |=> proc_valid_q ##0
        proc_data_q == $past(word[proc_sel]))
        else $error("processing stream not fed from selected channel");

    other_route_a: assert property (
        (dump && tdm_valid_q == 1'b0) |=> tdm_valid_q && tdm_data_q == $past(word[!proc_sel]))
        else $error("TDM stream not fed from the other channel");

    echo_target_a: assert property (
        $changed(proc_sel) |=> echo_cancel_ch_q == $past(proc_sel) ##1 $stable(echo_cancel_ch_q) [*1]
        or $changed(proc_sel))
        else $error("echo cancel target does not follow selection");

    hold_word_a: assert property (
        (proc_valid_q && !proc_ready) |=> proc_valid_q && $stable(proc_data_q))
        else $error("stalled processing word changed");

endmodule

/* test/pmc_mic_model.sv */
/*
 * Behavioural pair of PDM microphones sharing one data pin.
 * Assumes the capture block owns the clock; each microphone drives in its own clock phase.
 */
`timescale 1ns/1ps
module pmc_mic_model #(
    parameter logic HIGH_BIT = 1'b1,
    parameter logic LOW_BIT = 1'b0
) (
    // Microphone clock from the capture block.
    input wire logic pdm_clock_out_q,
    // Shared data pin.
    output logic pdm_data_in
);
    // The pin starts with the low-phase microphone driving.
    initial pdm_data_in = LOW_BIT;
    // Each microphone drives just after its edge, so the bit is settled well before sampling.
    always @(pdm_clock_out_q) begin
        pdm_data_in <= #2 (pdm_clock_out_q === 1'b1) ? HIGH_BIT : LOW_BIT;
    end
endmodule

/* test/test_pmc_capture.sv */
/*
 * Self-checking bench of the PDM microphone capture block.
 * Assumes the two-microphone model: the high-phase channel is all ones, the low-phase all zeros.
 */
`timescale 1ns/1ps
module test_pmc_capture;
    // Stimulus, driven at the falling clock edge.
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    pmc_pkg::pmc_mode_t mode = pmc_pkg::PMC_MODE_DUPLEX;
    logic tdm_a_present = 1'b1;
    pmc_pkg::pmc_rate_t tdm_a_rate = pmc_pkg::PMC_RATE_16K;
    logic proc_rate_16k = 1'b1;
    logic chan0_rising = 1'b1;
    logic proc_sel = 1'b0;
    logic proc_ready = 1'b0;
    logic tdm_ready = 1'b0;
    // Design outputs and the data pin.
    logic pdm_clock_out_q;
    logic pdm_data_in;
    logic proc_valid_q;
    logic [15:0] proc_data_q;
    logic tdm_valid_q;
    logic [15:0] tdm_data_q;
    logic echo_cancel_ch_q;
    logic overrun_q;
    int miscompares = 0;
    int checked = 0;
    int overruns = 0;

    pmc_capture dut (.clk(clk), .rst_b(rst_b), .mode(mode), .tdm_a_present(tdm_a_present),
        .tdm_a_rate(tdm_a_rate), .proc_rate_16k(proc_rate_16k), .chan0_rising(chan0_rising),
        .proc_sel(proc_sel), .pdm_clock_out_q(pdm_clock_out_q), .pdm_data_in(pdm_data_in),
        .proc_valid_q(proc_valid_q), .proc_ready(proc_ready), .proc_data_q(proc_data_q),
        .tdm_valid_q(tdm_valid_q), .tdm_ready(tdm_ready), .tdm_data_q(tdm_data_q),
        .echo_cancel_ch_q(echo_cancel_ch_q), .overrun_q(overrun_q));
    pmc_mic_model mics (.pdm_clock_out_q(pdm_clock_out_q), .pdm_data_in(pdm_data_in));

    // Clock of 4 ns period.
    initial forever #2 clk = ~clk;
    // Dropped words are counted here, since the pulse lasts one cycle only.
    // Sampled at the falling edge, where the registered pulse has settled.
    always @(negedge clk) if (overrun_q === 1'b1) overruns <= overruns + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Applies settings, then drains stale words; a change restarts the decimators.
    task automatic cfg(input pmc_pkg::pmc_mode_t m, input logic pr, input pmc_pkg::pmc_rate_t r,
                       input logic r16, input logic c0r, input logic sel);
        @(negedge clk);
        mode = m;
        tdm_a_present = pr;
        tdm_a_rate = r;
        proc_rate_16k = r16;
        chan0_rising = c0r;
        proc_sel = sel;
        proc_ready = 1'b1;
        tdm_ready = 1'b1;
        repeat (8) @(negedge clk);
        proc_ready = 1'b0;
        tdm_ready = 1'b0;
    endtask

    // Measures one high phase of the microphone clock in system cycles.
    task automatic half_period(input int lo, input int hi);
        int n;
        n = 0;
        while (pdm_clock_out_q !== 1'b0 && n < 1000) begin @(negedge clk); n++; end
        while (pdm_clock_out_q !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
        n = 0;
        while (pdm_clock_out_q === 1'b1 && n < 1000) begin @(negedge clk); n++; end
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    // Waits for a word on both streams, judges it and accepts it with a one-cycle ready.
    // The leading edge keeps ready low across one clock between two calls in a row.
    task automatic words(input logic [15:0] ep, input logic [15:0] et);
        int n;
        n = 0;
        @(negedge clk);
        while (!(proc_valid_q === 1'b1 && tdm_valid_q === 1'b1) && n < 40000) begin
            @(negedge clk);
            n++;
        end
        check(16'(n < 40000), 16'h0001);
        check(proc_data_q, ep);
        check(tdm_data_q, et);
        proc_ready = 1'b1;
        tdm_ready = 1'b1;
        @(negedge clk);
        proc_ready = 1'b0;
        tdm_ready = 1'b0;
    endtask

    task automatic test_slow_duplex();
        cfg(pmc_pkg::PMC_MODE_DUPLEX, 1'b1, pmc_pkg::PMC_RATE_8K, 1'b1, 1'b1, 1'b0);
        half_period(122, 123);
        words(16'(pmc_pkg::PMC_DEC_LO_16K), 16'h0000 - 16'(pmc_pkg::PMC_DEC_LO_16K));
        check(16'(echo_cancel_ch_q), 16'h0000);
        $display("test slow_duplex done");
    endtask

    task automatic test_crystal_swap();
        cfg(pmc_pkg::PMC_MODE_DUPLEX, 1'b0, pmc_pkg::PMC_RATE_16K, 1'b1, 1'b0, 1'b1);
        half_period(39, 41);
        words(16'(pmc_pkg::PMC_DEC_48K), 16'h0000 - 16'(pmc_pkg::PMC_DEC_48K));
        check(16'(echo_cancel_ch_q), 16'h0001);
        $display("test crystal_swap done");
    endtask

    task automatic test_fast_duplex();
        cfg(pmc_pkg::PMC_MODE_DUPLEX, 1'b1, pmc_pkg::PMC_RATE_48K, 1'b1, 1'b1, 1'b1);
        half_period(39, 41);
        words(16'h0000 - 16'(pmc_pkg::PMC_DEC_HI_16K), 16'(pmc_pkg::PMC_DEC_HI_16K));
        $display("test fast_duplex done");
    endtask

    task automatic test_asr();
        cfg(pmc_pkg::PMC_MODE_BARGE, 1'b1, pmc_pkg::PMC_RATE_48K, 1'b1, 1'b1, 1'b0);
        half_period(122, 123);
        cfg(pmc_pkg::PMC_MODE_ASR, 1'b1, pmc_pkg::PMC_RATE_48K, 1'b0, 1'b1, 1'b0);
        half_period(122, 123);
        words(16'(pmc_pkg::PMC_DEC_LO_8K), 16'h0000 - 16'(pmc_pkg::PMC_DEC_LO_8K));
        $display("test asr done");
    endtask

    // Three blocks with the receiver stalled: two words are kept, the third is dropped.
    task automatic test_overrun();
        int base;
        cfg(pmc_pkg::PMC_MODE_DUPLEX, 1'b0, pmc_pkg::PMC_RATE_16K, 1'b1, 1'b1, 1'b0);
        base = overruns;
        repeat (18000) @(negedge clk);
        check(16'(overruns - base), 16'h0001);
        words(16'(pmc_pkg::PMC_DEC_48K), 16'h0000 - 16'(pmc_pkg::PMC_DEC_48K));
        words(16'(pmc_pkg::PMC_DEC_48K), 16'h0000 - 16'(pmc_pkg::PMC_DEC_48K));
        check(16'({proc_valid_q, tdm_valid_q}), 16'h0000);
        $display("test overrun done");
    endtask

    // Main sequence after 12 cycles of reset.
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        test_slow_duplex();
        test_crystal_swap();
        test_fast_duplex();
        test_asr();
        test_overrun();
        test_done();
    end

    // Watchdog at 98000 cycles, past the roughly 86000 cycles the tests need.
    initial begin
        #392000;
        miscompares++;
        test_done();
    end
endmodule
